// File: design/adc_cfg_pkg.sv
// shared constants and types for the adc sequence/width/sample configuration block
package adc_cfg_pkg;
   localparam int CHANNELS = 8;
   localparam int CYCLES = 4;
   localparam int RAW_W = 10;
   localparam int RES_W = 12;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CLK_FREQ_MHZ = 1000 / CLK_PERIOD_NS;
   // register byte offsets
   localparam logic [7:0] OFF_CYCLE5_8_MASKS = 8'h1c;
   localparam logic [7:0] OFF_RESULT_WIDTH = 8'h24;
   localparam logic [7:0] OFF_SAMPLE_TIME_0_3 = 8'h28;
   localparam logic [7:0] OFF_SEQ_CONTROL = 8'h50;
   localparam logic [7:0] OFF_CLOCK_DIVIDER = 8'h54;
   localparam logic [7:0] OFF_LAST_RESULT = 8'h58;
   // reset values
   localparam logic [31:0] RST_CYCLE5_8_MASKS = 32'h0000_0000;
   localparam logic [7:0] RST_RESULT_WIDTH = 8'h00;
   localparam logic [31:0] RST_SAMPLE_TIME_0_3 = 32'h0000_0000;
   localparam logic [3:0] RST_CLOCK_DIVIDER = 4'h0;
   // field positions
   localparam int SEQ_RUN_BIT = 8;
   localparam int SEQ_CYCLE_LSB = 11;
   localparam int SEQ_CHAN_LSB = 16;
   localparam int SEQ_BUSY_BIT = 24;
   // conversion timing, in analog clock periods; SYNC_CLOCKS in module clocks
   localparam int SAMPLE_MIN_CYCLES = 2;
   localparam int CONV_BASE_CYCLES = 3;
   localparam int WIDTH_TEN = 10;
   localparam int WIDTH_EIGHT = 8;
   localparam int SYNC_CLOCKS = 1;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [2:0] chan;
      logic [7:0] extra_sample_cycles;
      logic width_eight;
   } conv_req_type;

   typedef enum logic [1:0] {CONV_IDLE, CONV_SAMPLE, CONV_STEPS, CONV_SYNC} conv_state_type;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_WAIT} seq_state_type;
endpackage : adc_cfg_pkg

// File: design/adc_conv_timer.sv
// conversion timing and result alignment for one channel conversion
`timescale 1ns/1ps
`default_nettype none
module adc_conv_timer
   import adc_cfg_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic analog_tick,
   input wire logic start,
   input wire conv_req_type req,
   input wire logic [RAW_W-1:0] raw_code,
   output logic busy,
   output logic sample_phase,
   output logic done,
   output logic [RES_W-1:0] result
);
   conv_state_type state_r;
   conv_req_type req_r;
   logic [8:0] cnt_r;
   logic [8:0] sample_seen_r;

   assign busy = (state_r != CONV_IDLE);
   assign sample_phase = (state_r == CONV_SAMPLE);

   // sample phase 2 + extra, then 1 + width steps, then one module clock
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= CONV_IDLE;
         cnt_r <= 9'h000;
         req_r <= '0;
      end else begin
         case (state_r)
            CONV_IDLE: begin
               if (start) begin
                  req_r <= req;
                  cnt_r <= 9'(SAMPLE_MIN_CYCLES - 1) + {1'b0, req.extra_sample_cycles};
                  state_r <= CONV_SAMPLE;
               end
            end
            CONV_SAMPLE: begin
               if (analog_tick) begin
                  if (cnt_r == 9'h000) begin
                     cnt_r <= req_r.width_eight ? 9'(CONV_BASE_CYCLES - SAMPLE_MIN_CYCLES
                        + WIDTH_EIGHT - 1) : 9'(CONV_BASE_CYCLES - SAMPLE_MIN_CYCLES
                        + WIDTH_TEN - 1);
                     state_r <= CONV_STEPS;
                  end else begin
                     cnt_r <= cnt_r - 9'h001;
                  end
               end
            end
            CONV_STEPS: begin
               if (analog_tick) begin
                  if (cnt_r == 9'h000) begin
                     state_r <= CONV_SYNC;
                  end else begin
                     cnt_r <= cnt_r - 9'h001;
                  end
               end
            end
            CONV_SYNC: state_r <= CONV_IDLE;
            default: state_r <= CONV_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done <= 1'b0;
      end else begin
         done <= (state_r == CONV_SYNC);
      end
   end

   // left-aligned at bit 11, unused low bits cleared
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result <= '0;
      end else if (state_r == CONV_SYNC) begin
         if (req_r.width_eight) begin
            result <= {raw_code[RAW_W-1:2], 4'h0};
         end else begin
            result <= {raw_code, 2'b00};
         end
      end
   end

   // helper: analog ticks seen in the sample phase
   always_ff @(posedge aclk) begin
      if (!aresetn || state_r == CONV_IDLE) begin
         sample_seen_r <= 9'h000;
      end else if (sample_phase && analog_tick) begin
         sample_seen_r <= sample_seen_r + 9'h001;
      end
   end

   chk_sample_length: assert property (@(posedge aclk) disable iff (!aresetn)
      sample_phase |->
      sample_seen_r < 9'(SAMPLE_MIN_CYCLES) + {1'b0, req_r.extra_sample_cycles})
      else $error("sample phase too long");
   chk_sample_ticks: assert property (@(posedge aclk) disable iff (!aresetn)
      ($past(state_r) == CONV_SAMPLE && state_r == CONV_STEPS) |->
      (sample_seen_r == 9'(SAMPLE_MIN_CYCLES) + {1'b0, req_r.extra_sample_cycles}))
      else $error("sample phase length wrong");
   chk_eight_low_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (done && req_r.width_eight) |-> result[3:0] == 4'h0)
      else $error("eight bit result low bits not zero");
   chk_ten_alignment: assert property (@(posedge aclk) disable iff (!aresetn)
      (done && !req_r.width_eight) |-> result == {$past(raw_code), 2'b00})
      else $error("ten bit result misaligned");
   chk_sync_done: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_r == CONV_SYNC) |=> done && state_r == CONV_IDLE)
      else $error("sync step not one clock");
endmodule : adc_conv_timer
`default_nettype wire

// File: design/adc_seq_cfg.sv
// axi4-lite register file, cycle 5-8 sequencer and conversion control
`timescale 1ns/1ps
`default_nettype none
module adc_seq_cfg
   import adc_cfg_pkg::*;
#(
   parameter int NUM_CHANNELS = CHANNELS
)(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [RAW_W-1:0] raw_code,
   output logic sample_phase,
   output logic conv_start,
   output logic [2:0] conv_channel,
   output logic conv_done,
   output logic [RES_W-1:0] conv_result
);
   if (NUM_CHANNELS != CHANNELS) begin : g_bad_channels
      $error("only eight channels supported");
   end

   logic [31:0] cycle5_8_channel_masks_r;
   logic [7:0] result_width_select_r;
   logic [31:0] sample_time_ch0_3_r;
   logic sequencer_run_r;
   logic [3:0] analog_clock_divider_r;
   logic [3:0] div_cnt_r;
   logic analog_tick;
   logic aw_held_r, w_held_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic wr_go;
   logic wr_hit;
   seq_state_type seq_r;
   logic [1:0] cycle_r;
   logic [2:0] chan_r;
   logic conv_busy;
   conv_req_type req;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
      input logic [3:0] strb);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) v[i*8 +: 8] = data[i*8 +: 8];
      end
      return v;
   endfunction : merge

   function automatic logic mapped(input logic [7:0] a);
      return a == OFF_CYCLE5_8_MASKS || a == OFF_RESULT_WIDTH || a == OFF_SAMPLE_TIME_0_3
         || a == OFF_SEQ_CONTROL || a == OFF_CLOCK_DIVIDER || a == OFF_LAST_RESULT;
   endfunction : mapped

   // write channels taken independently, answered once both are held
   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
   assign wr_hit = mapped(aw_addr_r);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_r <= 1'b1;
         aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end else if (wr_go) begin
         aw_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_r <= 1'b1;
         w_data_r <= s_axi_wdata;
         w_strb_r <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_r <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cycle5_8_channel_masks_r <= RST_CYCLE5_8_MASKS;
         result_width_select_r <= RST_RESULT_WIDTH;
         sample_time_ch0_3_r <= RST_SAMPLE_TIME_0_3;
         analog_clock_divider_r <= RST_CLOCK_DIVIDER;
      end else if (wr_go) begin
         case (aw_addr_r)
            OFF_CYCLE5_8_MASKS: cycle5_8_channel_masks_r <=
               merge(cycle5_8_channel_masks_r, w_data_r, w_strb_r);
            OFF_RESULT_WIDTH: if (w_strb_r[0]) result_width_select_r <= w_data_r[7:0];
            OFF_SAMPLE_TIME_0_3: sample_time_ch0_3_r <=
               merge(sample_time_ch0_3_r, w_data_r, w_strb_r);
            OFF_CLOCK_DIVIDER: if (w_strb_r[0]) analog_clock_divider_r <= w_data_r[3:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sequencer_run_r <= 1'b0;
      end else if (wr_go && aw_addr_r == OFF_SEQ_CONTROL && w_strb_r[1]) begin
         sequencer_run_r <= w_data_r[SEQ_RUN_BIT];
      end
   end

   // read path: one request at a time, answered the next clock
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= mapped({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
         case ({s_axi_araddr[7:2], 2'b00})
            OFF_CYCLE5_8_MASKS: s_axi_rdata <= cycle5_8_channel_masks_r;
            OFF_RESULT_WIDTH: s_axi_rdata <= {24'h00_0000, result_width_select_r};
            OFF_SAMPLE_TIME_0_3: s_axi_rdata <= sample_time_ch0_3_r;
            OFF_SEQ_CONTROL: s_axi_rdata <= {7'h00, conv_busy, 5'h00, chan_r, 2'b00,
               1'b0, cycle_r, 2'b00, sequencer_run_r, 8'h00};
            OFF_CLOCK_DIVIDER: s_axi_rdata <= {28'h000_0000, analog_clock_divider_r};
            OFF_LAST_RESULT: s_axi_rdata <= {20'h0_0000, conv_result};
            default: s_axi_rdata <= 32'h0000_0000;
         endcase
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // analog clock: one tick every divider+1 module clocks
   assign analog_tick = (div_cnt_r == analog_clock_divider_r);

   always_ff @(posedge aclk) begin
      if (!aresetn || analog_tick) begin
         div_cnt_r <= 4'h0;
      end else begin
         div_cnt_r <= div_cnt_r + 4'h1;
      end
   end

   // sequencer over cycles 5..8, channels scanned from 7 down to 0
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_r <= SEQ_IDLE;
         cycle_r <= 2'b00;
         chan_r <= 3'h0;
      end else begin
         case (seq_r)
            SEQ_IDLE: begin
               // status reads zero after reset; scan restarts at cycle five, channel 7
               if (sequencer_run_r) begin
                  seq_r <= SEQ_SCAN;
                  chan_r <= 3'h7;
                  cycle_r <= 2'b00;
               end
            end
            SEQ_SCAN: begin
               if (!sequencer_run_r) begin
                  seq_r <= SEQ_IDLE;
               end else if (cycle5_8_channel_masks_r[{cycle_r, chan_r}]) begin
                  seq_r <= SEQ_WAIT;
               end else begin
                  chan_r <= chan_r - 3'h1;
                  if (chan_r == 3'h0) cycle_r <= cycle_r + 2'b01;
               end
            end
            SEQ_WAIT: begin
               if (conv_done) begin
                  seq_r <= SEQ_SCAN;
                  chan_r <= chan_r - 3'h1;
                  if (chan_r == 3'h0) cycle_r <= cycle_r + 2'b01;
               end
            end
            default: seq_r <= SEQ_IDLE;
         endcase
      end
   end

   assign conv_start = (seq_r == SEQ_SCAN) && sequencer_run_r
      && cycle5_8_channel_masks_r[{cycle_r, chan_r}];
   assign conv_channel = chan_r;
   assign req = '{chan: chan_r,
      extra_sample_cycles: chan_r[2] ? 8'h00 : sample_time_ch0_3_r[chan_r[1:0]*8 +: 8],
      width_eight: result_width_select_r[chan_r]};

   adc_conv_timer u_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .analog_tick(analog_tick),
      .start(conv_start),
      .req(req),
      .raw_code(raw_code),
      .busy(conv_busy),
      .sample_phase(sample_phase),
      .done(conv_done),
      .result(conv_result)
   );

   chk_mask_reset: assert property (@(posedge aclk)
      !aresetn |=> cycle5_8_channel_masks_r == 32'h0 && sample_time_ch0_3_r == 32'h0
      && result_width_select_r == 8'h00) else $error("registers not cleared by reset");
   chk_skip_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (seq_r == SEQ_SCAN && sequencer_run_r && !cycle5_8_channel_masks_r[{cycle_r, chan_r}])
      |-> !conv_start ##1 seq_r == SEQ_SCAN && chan_r == $past(chan_r) - 3'h1)
      else $error("disabled channel not skipped");
   chk_stopped_idle: assert property (@(posedge aclk) disable iff (!aresetn)
      (!sequencer_run_r && seq_r != SEQ_WAIT) |-> !conv_start ##1 seq_r == SEQ_IDLE)
      else $error("sequencer not stopped");
   chk_width_read: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == OFF_RESULT_WIDTH[7:2])
      |=> s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[7:0] == $past(result_width_select_r))
      else $error("width register read wrong");
   chk_width_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      (conv_done && $past(result_width_select_r[conv_channel])) |-> conv_result[3:0] == 4'h0)
      else $error("eight bit channel result not aligned");
   chk_write_resp: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_go && aw_addr_r == OFF_CYCLE5_8_MASKS && w_strb_r == 4'hf |=>
      s_axi_bvalid && cycle5_8_channel_masks_r == $past(w_data_r))
      else $error("mask write not stored");
endmodule : adc_seq_cfg
`default_nettype wire

// File: test/adc_sequence_width_sample_cfg_tb.sv
// self-checking bench for the adc sequence/width/sample configuration block
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_width_sample_cfg_tb;
   import adc_cfg_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'h0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready = 1'b0;
   logic [7:0] s_axi_araddr = 8'h00;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready = 1'b0;
   logic [RAW_W-1:0] raw_code = 10'h000;
   logic sample_phase;
   logic conv_start;
   logic [2:0] conv_channel;
   logic conv_done;
   logic [RES_W-1:0] conv_result;
   int n_errors = 0;
   int n_tests = 0;
   int seed = 32'hcd74;
   int exp_q[$];
   logic [31:0] masks, widths, stcs, rd;
   logic [RAW_W-1:0] cur_raw;
   int cur_ch, t0, cyc, samp_cnt, n_done, n_starts, ex, nw, tmp;
   bit in_conv = 1'b0;

   adc_seq_cfg uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .raw_code(raw_code),
      .sample_phase(sample_phase), .conv_start(conv_start), .conv_channel(conv_channel),
      .conv_done(conv_done), .conv_result(conv_result));

   initial begin
      forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
   end

   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic timed_out(input string name);
      n_errors++;
      $display("MISMATCH %s expected handshake seen timeout", name);
      print_verdict();
   endtask : timed_out

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                            input logic [1:0] exp_resp);
      bit aw_ok, w_ok;
      int n;
      aw_ok = 0;
      w_ok = 0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 100 && !(aw_ok && w_ok); n++) begin
         @(posedge aclk);
         if (!aw_ok && s_axi_awready) begin
            aw_ok = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_ok && s_axi_wready) begin
            w_ok = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      if (!(aw_ok && w_ok)) timed_out("write_address_data");
      s_axi_bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (s_axi_bvalid) break;
      end
      if (n == 100) timed_out("write_response");
      s_axi_bready <= 1'b0;
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, exp_resp});
   endtask : axi_write

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           input logic [1:0] exp_resp);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (s_axi_arready) break;
      end
      if (n == 100) timed_out("read_address");
      s_axi_arvalid <= 1'b0;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (s_axi_rvalid) break;
      end
      if (n == 100) timed_out("read_data");
      s_axi_rready <= 1'b0;
      d = s_axi_rdata;
      check("rresp", {30'h0, s_axi_rresp}, {30'h0, exp_resp});
   endtask : axi_read

   task automatic reset_reads;
      logic [7:0] offs [5];
      offs = '{OFF_CYCLE5_8_MASKS, OFF_RESULT_WIDTH, OFF_SAMPLE_TIME_0_3,
               OFF_SEQ_CONTROL, OFF_CLOCK_DIVIDER};
      foreach (offs[i]) begin
         axi_read(offs[i], rd, RESP_OKAY);
         check("reset_value", rd, 32'h0);
      end
   endtask : reset_reads

   // expected scan order: cycles five to eight, channel 7 down to 0
   task automatic build_queue;
      exp_q.delete();
      for (int r = 0; r < 4; r++) begin
         for (int c = 0; c < CYCLES; c++) begin
            for (int ch = CHANNELS - 1; ch >= 0; ch--) begin
               if (masks[c * 8 + ch]) exp_q.push_back(ch);
            end
         end
      end
   endtask : build_queue

   // conversion monitor and reference model
   always @(posedge aclk) begin
      if (!aresetn) begin
         in_conv = 0;
      end else begin
         if (in_conv && sample_phase) samp_cnt++;
         if (conv_done && in_conv) begin
            ex = (cur_ch < 4) ? int'(stcs[cur_ch * 8 +: 8]) : 0;
            nw = widths[cur_ch] ? WIDTH_EIGHT : WIDTH_TEN;
            check("conv_result", {20'h0, conv_result}, widths[cur_ch] ?
                  {20'h0, cur_raw[9:2], 4'h0} : {20'h0, cur_raw, 2'b00});
            check("conv_time", cyc - t0, CONV_BASE_CYCLES + ex + nw + 2);
            check("sample_len", samp_cnt, SAMPLE_MIN_CYCLES + ex);
            in_conv = 0;
            n_done++;
         end
         if (conv_start) begin
            n_starts++;
            if (exp_q.size() == 0) begin
               check("unexpected_start", 32'h1, 32'h0);
            end else begin
               cur_ch = exp_q.pop_front();
               check("conv_channel", {29'h0, conv_channel}, cur_ch);
            end
            in_conv = 1;
            t0 = cyc;
            samp_cnt = 0;
            cur_raw = RAW_W'($random(seed));
            raw_code <= cur_raw;
         end
      end
      cyc++;
   end

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      reset_reads();
      axi_read(8'h30, rd, RESP_SLVERR);
      check("unmapped_data", rd, 32'h0);
      axi_write(8'h20, 32'hffff_ffff, 4'hf, RESP_SLVERR);
      for (int c = 0; c < CYCLES; c++) begin
         tmp = $random(seed);
         masks[c * 8 +: 8] = (tmp[7:0] == 8'h00) ? 8'h01 : tmp[7:0];
      end
      widths = $random(seed);
      stcs = $random(seed) & 32'h0707_0707;
      stcs[7:0] = 8'h07;
      axi_write(OFF_CYCLE5_8_MASKS, masks, 4'hf, RESP_OKAY);
      axi_write(OFF_RESULT_WIDTH, widths, 4'hf, RESP_OKAY);
      axi_write(OFF_SAMPLE_TIME_0_3, stcs, 4'hf, RESP_OKAY);
      axi_write(OFF_RESULT_WIDTH, ~widths, 4'b0010, RESP_OKAY);
      axi_read(OFF_CYCLE5_8_MASKS, rd, RESP_OKAY);
      check("cycle5_8_channel_masks", rd, masks);
      axi_read(OFF_RESULT_WIDTH, rd, RESP_OKAY);
      check("result_width_select", rd, {24'h0, widths[7:0]});
      axi_read(OFF_SAMPLE_TIME_0_3, rd, RESP_OKAY);
      check("sample_time_ch0_3", rd, stcs);
      build_queue();
      axi_write(OFF_SEQ_CONTROL, 32'h0000_0100, 4'b0010, RESP_OKAY);
      axi_read(OFF_SEQ_CONTROL, rd, RESP_OKAY);
      check("run_bit_set", {31'h0, rd[SEQ_RUN_BIT]}, 32'h1);
      for (tmp = 0; tmp < 20000 && n_done < 12; tmp++) @(posedge aclk);
      if (n_done < 12) timed_out("conversions");
      axi_write(OFF_SEQ_CONTROL, 32'h0, 4'b0010, RESP_OKAY);
      axi_read(OFF_SEQ_CONTROL, rd, RESP_OKAY);
      check("run_bit_clear", {31'h0, rd[SEQ_RUN_BIT]}, 32'h0);
      repeat (100) @(posedge aclk);
      tmp = n_starts;
      repeat (100) @(posedge aclk);
      check("stopped_starts", n_starts, tmp);
      build_queue();
      axi_write(OFF_SEQ_CONTROL, 32'h0000_0100, 4'b0010, RESP_OKAY);
      tmp = n_done;
      for (int n = 0; n < 2000 && n_done < tmp + 2; n++) @(posedge aclk);
      if (n_done < tmp + 2) timed_out("second_run");
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      reset_reads();
      print_verdict();
   end

   initial begin
      repeat (90000) @(posedge aclk);
      timed_out("run_length");
   end
endmodule : adc_sequence_width_sample_cfg_tb
`default_nettype wire
